// ---- inc/gdio_pkg.sv ----
// Constants shared by the general digital I/O port design.
package gdio_pkg;
    // ==========================================================
    // Widths and register indices on the core's I/O port
    // ==========================================================
    localparam int          GDIO_PIN_W        = 8;
    localparam int          GDIO_ADDR_W       = 2;
    localparam logic [1:0]  GDIO_IDX_INPUT    = 2'h0;
    localparam logic [1:0]  GDIO_IDX_DIR      = 2'h1;
    localparam logic [1:0]  GDIO_IDX_OUTDATA  = 2'h2;
    // ==========================================================
    // Reset values and single-bit operation codes
    // ==========================================================
    localparam logic [7:0]  GDIO_RST_OUTDATA  = 8'h00;
    localparam logic [7:0]  GDIO_RST_DIR      = 8'h00;
    localparam logic [7:0]  GDIO_RST_SYNC     = 8'h00;
    localparam logic [1:0]  GDIO_BITOP_NONE   = 2'h0;
    localparam logic [1:0]  GDIO_BITOP_SET    = 2'h1;
    localparam logic [1:0]  GDIO_BITOP_CLEAR  = 2'h2;
    // Pin level to read-back delay for a software-driven value, in cycles.
    localparam int          GDIO_SYNC_CYCLES  = 1;
endpackage

// ---- logic/gdio_port.sv ----
// One eight-pin general digital I/O port with its three I/O registers.
`timescale 1ns/100ps
module gdio_port
#(
    parameter int PINS = gdio_pkg::GDIO_PIN_W
)
(
    input  wire logic                         clock,
    input  wire logic                         rstn,
    input  wire logic [gdio_pkg::GDIO_ADDR_W-1:0] io_addr,
    input  wire logic                         io_wr,
    input  wire logic                         io_rd,
    input  wire logic [PINS-1:0]              io_wdata,
    input  wire logic [1:0]                   io_bit_op,
    input  wire logic [2:0]                   io_bit_sel,
    output logic      [PINS-1:0]              io_rdata,
    input  wire logic                         global_pullup_disable,
    input  wire logic                         sleep_clamp,
    input  wire logic [PINS-1:0]              clamp_override,
    input  wire logic [PINS-1:0]              pin_in,
    output logic      [PINS-1:0]              pin_out,
    output logic      [PINS-1:0]              pin_oe,
    output logic      [PINS-1:0]              pin_pullup
);
    import gdio_pkg::*;

    // ==========================================================
    // Reset release
    // ==========================================================
    // Assertion is asynchronous so the pins float at once with no clock.
    logic       rst_meta_reg;
    logic       rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // ==========================================================
    // Input path
    // ==========================================================
    logic [PINS-1:0] pin_gated;
    logic [PINS-1:0] pin_sync;

    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++)
        begin : g_clamp
            // Each pin has its own override, so other pins stay general I/O.
            assign pin_gated[gi] = pin_in[gi]
                                   & ~(sleep_clamp & ~clamp_override[gi]);
        end
    endgenerate

    gdio_sync #(.WIDTH(PINS)) u_sync
    (
        .clock (clock),
        .rst_n (rst_n),
        .din   (pin_gated),
        .dout  (pin_sync)
    );

    // ==========================================================
    // Registers and pin drive
    // ==========================================================
    logic [PINS-1:0] outdata_reg, outdata_next;
    logic [PINS-1:0] dir_reg, dir_next;
    logic [PINS-1:0] rdata_reg, rdata_next;
    logic [PINS-1:0] out_reg, out_next;
    logic [PINS-1:0] oe_reg, oe_next;
    logic [PINS-1:0] pu_reg, pu_next;
    logic [PINS-1:0] wmask;
    logic [PINS-1:0] wval;

    always_comb
    begin
        // A bit operation touches one lane only; a plain write all lanes.
        if (io_bit_op == GDIO_BITOP_NONE)
        begin
            wmask = '1;
            wval  = io_wdata;
        end
        else
        begin
            wmask = PINS'(1) << io_bit_sel;
            wval  = (io_bit_op == GDIO_BITOP_SET) ? wmask : '0;
        end
        outdata_next = outdata_reg;
        dir_next     = dir_reg;
        if (io_wr)
        begin
            unique case (io_addr)
                GDIO_IDX_OUTDATA:
                    outdata_next = (outdata_reg & ~wmask) | (wval & wmask);
                GDIO_IDX_DIR:
                    dir_next = (dir_reg & ~wmask) | (wval & wmask);
                // The input location stores nothing; a one only flips the data bit.
                GDIO_IDX_INPUT:
                    outdata_next = outdata_reg ^ (wval & wmask);
                default:
                    outdata_next = outdata_reg;
            endcase
        end
        rdata_next = '0;
        if (io_rd)
        begin
            unique case (io_addr)
                GDIO_IDX_OUTDATA: rdata_next = outdata_reg;
                GDIO_IDX_DIR:     rdata_next = dir_reg;
                GDIO_IDX_INPUT:   rdata_next = pin_sync;
                default:          rdata_next = '0;
            endcase
        end
        oe_next  = dir_next;
        out_next = outdata_next & dir_next;
        // The global disable wins over every per-pin setting.
        pu_next  = ~dir_next & outdata_next
                   & {PINS{~global_pullup_disable}};
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            outdata_reg <= GDIO_RST_OUTDATA[PINS-1:0];
            dir_reg     <= GDIO_RST_DIR[PINS-1:0];
            rdata_reg   <= '0;
            out_reg     <= '0;
            oe_reg      <= '0;
            pu_reg      <= '0;
        end
        else
        begin
            outdata_reg <= outdata_next;
            dir_reg     <= dir_next;
            rdata_reg   <= rdata_next;
            out_reg     <= out_next;
            oe_reg      <= oe_next;
            pu_reg      <= pu_next;
        end
    end

    assign io_rdata   = rdata_reg;
    assign pin_out    = out_reg;
    assign pin_oe     = oe_reg;
    assign pin_pullup = pu_reg;

    // ==========================================================
    // Checks
    // ==========================================================
    // Pin outputs are registered from the next values, so they are compared
    // with the registers of the same edge, never with those of the cycle before.
    a_reset_tristate: assert property (
        @(posedge clock) !rst_n |-> (oe_reg == '0 && pu_reg == '0))
        else $error("pins not floating in reset");
    a_dir_drives: assert property (
        @(posedge clock) disable iff (!rst_n) oe_reg == dir_reg)
        else $error("driver enable differs from direction");
    a_out_value: assert property (
        @(posedge clock) disable iff (!rst_n)
        (out_reg & oe_reg) == (outdata_reg & dir_reg))
        else $error("driven level differs from data");
    a_pullup_off: assert property (
        @(posedge clock) disable iff (!rst_n)
        (pu_reg & (dir_reg | ~outdata_reg)) == '0)
        else $error("pull-up on for output or zero data");
    a_pud_kills: assert property (
        @(posedge clock) disable iff (!rst_n)
        $past(global_pullup_disable) |-> pu_reg == '0)
        else $error("pull-up on while globally disabled");
    a_pullup_on: assert property (
        @(posedge clock) disable iff (!rst_n)
        !$past(global_pullup_disable) |-> pu_reg == (~dir_reg & outdata_reg))
        else $error("pull-up missing for input with data one");
    a_toggle_write: assert property (
        @(posedge clock) disable iff (!rst_n)
        (io_wr && io_addr == GDIO_IDX_INPUT && io_bit_op == GDIO_BITOP_NONE)
        |=> outdata_reg == ($past(outdata_reg) ^ $past(io_wdata)))
        else $error("input-location write did not toggle data");
    a_bit_isolated: assert property (
        @(posedge clock) disable iff (!rst_n)
        (io_wr && io_addr == GDIO_IDX_DIR && io_bit_op != GDIO_BITOP_NONE)
        |=> ((dir_reg ^ $past(dir_reg)) & ~(PINS'(1) << $past(io_bit_sel))) == '0)
        else $error("bit operation changed another pin");
    a_input_ro: assert property (
        @(posedge clock) disable iff (!rst_n)
        (io_wr && io_addr == GDIO_IDX_INPUT) |=> dir_reg == $past(dir_reg))
        else $error("input-location write changed direction");
    a_read_sync: assert property (
        @(posedge clock) disable iff (!rst_n)
        (io_rd && io_addr == GDIO_IDX_INPUT) |=> io_rdata == $past(pin_sync))
        else $error("input read not from synchronizer");
    a_sleep_clamp: assert property (
        @(posedge clock) disable iff (!rst_n)
        $past(sleep_clamp) |-> (pin_sync & ~$past(clamp_override)) == '0)
        else $error("clamped input not low");
    a_other_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        (io_wr && io_addr == GDIO_IDX_DIR) |=> outdata_reg == $past(outdata_reg))
        else $error("direction write changed output data");
    a_quiet_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        !io_wr |=> (dir_reg == $past(dir_reg) && outdata_reg == $past(outdata_reg)))
        else $error("configuration changed without a write");
    a_read_idle: assert property (
        @(posedge clock) disable iff (!rst_n)
        !io_rd |=> io_rdata == '0)
        else $error("read data left standing");
endmodule

// ---- logic/gdio_sync.sv ----
// Latch-plus-flop input synchronizer, one stage pair per pin.
`timescale 1ns/100ps
module gdio_sync
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    import gdio_pkg::*;

    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] sync_reg;

    // ==========================================================
    // Front stage: open while the clock is high, holds while low
    // ==========================================================
    // A change near the falling edge settles during the low phase, so the
    // flop below never sees a moving input.
    always_latch
    begin
        if (clock)
        begin
            latch_q = din;
        end
    end

    // ==========================================================
    // Back stage: captured on the next rising edge
    // ==========================================================
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_reg <= GDIO_RST_SYNC[WIDTH-1:0];
        end
        else
        begin
            sync_reg <= latch_q;
        end
    end

    assign dout = sync_reg;
endmodule

// ---- tb/gdio_pin_model.sv ----
// Board-side model of what hangs on the port pins: external drivers and pull-up resolution.
`timescale 1ns/100ps
module gdio_pin_model
(
    input  wire logic       clock,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_level
);
    logic [7:0] float_pat = 8'h55;
    // An undriven pin without pull-up wanders every cycle, so a stale value never reads back.
    always @(posedge clock)
        float_pat <= ~float_pat;
    always_comb
        for (int i = 0; i < 8; i++)
            pin_level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                           pin_pullup[i] ? 1'b1 : float_pat[i];
endmodule

// ---- tb/general_digital_io_port_test.sv ----
// Self-checking bench for the general digital I/O port.
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module general_digital_io_port_test;
    import gdio_pkg::*;
    logic       clock = 1'b0;
    logic       run = 1'b1;
    logic       rstn = 1'b0;
    logic       io_wr = 1'b0;
    logic       io_rd = 1'b0;
    logic       global_pullup_disable = 1'b0;
    logic       sleep_clamp = 1'b0;
    logic [1:0] io_addr = 2'h0;
    logic [1:0] io_bit_op = 2'h0;
    logic [2:0] io_bit_sel = 3'h0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] clamp_override = 8'h00;
    logic [7:0] ext_en = 8'hFF;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] pin_level, io_rdata, pin_out, pin_oe, pin_pullup, rd;
    int         n_fail = 0;
    int         comparisons = 0;
    // ==========================================================
    // Clock, design and pins
    // ==========================================================
    always #5 if (run) clock = ~clock;
    gdio_port uut (.clock(clock), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_bit_op(io_bit_op), .io_bit_sel(io_bit_sel),
        .io_rdata(io_rdata), .global_pullup_disable(global_pullup_disable),
        .sleep_clamp(sleep_clamp), .clamp_override(clamp_override), .pin_in(pin_level),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
    gdio_pin_model pins (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_level));
    // ==========================================================
    // Register access tasks
    // ==========================================================
    task automatic wr(input logic [1:0] a, input logic [7:0] d,
                      input logic [1:0] op = GDIO_BITOP_NONE, input logic [2:0] s = 3'h0);
        @(posedge clock);
        io_addr <= a;
        io_wdata <= d;
        io_bit_op <= op;
        io_bit_sel <= s;
        io_wr <= 1'b1;
        @(posedge clock);
        io_wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clock);
        io_rd <= 1'b0;
        #1;
        d = io_rdata;
    endtask
    task automatic results;
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_fail++;
        results();
    end
    // ==========================================================
    // Scenarios
    // ==========================================================
    initial
    begin
        repeat (12) @(posedge clock);
        `CHK(pin_oe | pin_pullup, 8'h00)
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        for (int a = 0; a < 4; a++)
        begin
            rd_reg(a[1:0], rd);
            `CHK(rd, 8'h00)
        end
        // Pins 0 and 2 go from tri-state to output high through pull-up input.
        wr(GDIO_IDX_OUTDATA, 8'hA5);
        wr(GDIO_IDX_DIR, 8'h0F);
        `CHK(pin_oe, 8'h0F)
        `CHK(pin_out, 8'h05)
        `CHK(pin_pullup, 8'hA0)
        @(posedge clock);
        ext_en <= 8'h5F;
        ext_val <= 8'h3C;
        rd_reg(GDIO_IDX_INPUT, rd);
        `CHK(rd, 8'hB5)
        rd_reg(GDIO_IDX_DIR, rd);
        `CHK(rd, 8'h0F)
        rd_reg(GDIO_IDX_OUTDATA, rd);
        `CHK(rd, 8'hA5)
        @(posedge clock);
        ext_en <= 8'hFF;
        global_pullup_disable <= 1'b1;
        @(posedge clock);
        #1;
        `CHK({pin_pullup, pin_oe}, 16'h000F)
        @(posedge clock);
        global_pullup_disable <= 1'b0;
        wr(GDIO_IDX_INPUT, 8'h0F);
        wr(GDIO_IDX_INPUT, 8'h00);
        rd_reg(GDIO_IDX_OUTDATA, rd);
        `CHK(rd, 8'hAA)
        rd_reg(GDIO_IDX_INPUT, rd);
        `CHK(rd, 8'h3A)
        wr(GDIO_IDX_DIR, 8'h00, GDIO_BITOP_SET, 3'h7);
        wr(GDIO_IDX_OUTDATA, 8'hFF, GDIO_BITOP_CLEAR, 3'h1);
        rd_reg(GDIO_IDX_DIR, rd);
        `CHK(rd, 8'h8F)
        rd_reg(GDIO_IDX_OUTDATA, rd);
        `CHK(rd, 8'hA8)
        `CHK(pin_out, 8'h88)
        `CHK(pin_pullup, 8'h20)
        // Pin 5 leaves pull-up input for output low by way of output high.
        wr(GDIO_IDX_DIR, 8'h00, GDIO_BITOP_SET, 3'h5);
        `CHK({pin_oe, pin_out, pin_pullup}, 24'hAFA800)
        wr(GDIO_IDX_OUTDATA, 8'h00, GDIO_BITOP_CLEAR, 3'h5);
        `CHK({pin_oe, pin_out, pin_pullup}, 24'hAF8800)
        wr(2'h3, 8'hFF);
        rd_reg(2'h3, rd);
        `CHK(rd, 8'h00)
        rd_reg(GDIO_IDX_DIR, rd);
        `CHK(rd, 8'hAF)
        @(posedge clock);
        sleep_clamp <= 1'b1;
        clamp_override <= 8'h08;
        rd_reg(GDIO_IDX_INPUT, rd);
        `CHK(rd, 8'h08)
        @(posedge clock);
        clamp_override <= 8'h00;
        rd_reg(GDIO_IDX_INPUT, rd);
        `CHK(rd, 8'h00)
        @(posedge clock);
        sleep_clamp <= 1'b0;
        // Reset with the clock stopped must still release every pin.
        @(negedge clock);
        run = 1'b0;
        #20 rstn = 1'b0;
        #20 `CHK(pin_oe | pin_pullup, 8'h00)
        run = 1'b1;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        rd_reg(GDIO_IDX_DIR, rd);
        `CHK(rd, 8'h00)
        results();
    end
endmodule
